// ==== inc/pmb_pkg.sv ====
// Constants, types and register map of the fabric-to-link bridge mode block
// ============================================================
// Overview of operation
// - Datapath between link and fabric is built as 64 or 128 bits, or 32 bits in one-word responder role.
// - Requester/completer role both originates link requests and accepts incoming ones.
// - Completer-only role accepts requests and sends completions, never originates requests.
// - Completer-only role leaves out the fabric transmit slave port.
// - One-word responder role is unpipelined with at most one request outstanding.
// - One-word responder role gives receive BAR masters 32-bit data always.
// - Control slave port, always present in requester/completer role and optional in completer-only role, lets fabric masters read and write bridge registers.
// - Control slave port never present in one-word responder role.
// - Multiple-message option exports MSI and MSI-X interfaces to application logic.
// - Interrupt enable powers up set when auto-enable is on, clear otherwise.
// - Auto-enable sets only the power-up value; later enable writes act normally.
package pmb_pkg;

   // ============================================================
   // Build-time roles and widths
   typedef enum logic [1:0] {
      ROLE_REQ_CPL  = 2'h0,
      ROLE_CPL_ONLY = 2'h1,
      ROLE_ONE_WORD = 2'h2
   } pmb_role_t;

   localparam int MAX_W  = 128;
   localparam int WIDE_W = 128;
   localparam int NARROW_W = 64;
   localparam int WORD_W = 32;
   localparam int ADDR_W = 32;
   localparam int TAG_W  = 8;
   localparam int EV_W   = 3;
   localparam int MSI_NUM_W  = 5;
   localparam int MSIX_IDX_W = 11;

   // ============================================================
   // Link and fabric carriers
   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [TAG_W-1:0]  tag;
      logic [MAX_W-1:0]  data;
   } pmb_req_t;

   typedef struct packed {
      logic [TAG_W-1:0] tag;
      logic [MAX_W-1:0] data;
   } pmb_cpl_t;

   // ============================================================
   // Control slave register map (byte addresses)
   localparam logic [11:0] OFS_ISR = 12'h000;
   localparam logic [11:0] OFS_IER = 12'h004;
   localparam logic [11:0] OFS_CFG = 12'h008;

   // Event bits, shared by status and enable registers
   localparam int EV_RX_TAKEN = 0;
   localparam int EV_CPL_SENT = 1;
   localparam int EV_TX_SENT  = 2;

   localparam logic [EV_W-1:0] IER_ON  = 3'h7;
   localparam logic [EV_W-1:0] IER_OFF = 3'h0;

   // Configuration readback field positions
   localparam int CFG_ROLE_LSB = 0;
   localparam int CFG_WIDE_BIT = 4;
   localparam int CFG_MSI_BIT  = 5;
   localparam int CFG_AUTO_BIT = 6;

   // Outstanding request limit in pipelined roles and in one-word role
   localparam logic [1:0] PIPE_DEPTH = 2'h2;
   localparam logic [1:0] ONE_DEPTH  = 2'h1;

endpackage

// ==== design/pmb_bridge_mode.sv ====
// Bridge datapath, role selection, control register slave and interrupt logic
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module pmb_bridge_mode #(
   parameter pmb_pkg::pmb_role_t ROLE          = pmb_pkg::ROLE_REQ_CPL,
   parameter bit                 WIDE_DATA     = 1'b0,
   parameter bit                 CTRL_PORT_OPT = 1'b1,
   parameter bit                 MULTI_MSI     = 1'b0,
   parameter bit                 AUTO_IRQ_EN   = 1'b0
) (
   // Clock and reset
   input  wire logic                             CLK,
   input  wire logic                             RST,
   // Control register slave (APB)
   input  wire logic                             PSEL,
   input  wire logic                             PENABLE,
   input  wire logic                             PWRITE,
   input  wire logic [11:0]                      PADDR,
   input  wire logic [31:0]                      PWDATA,
   output logic [31:0]                           PRDATA,
   output logic                                  PREADY,
   output logic                                  PSLVERR,
   // Incoming link requests
   input  wire logic                             LINK_RX_VALID,
   input  wire pmb_pkg::pmb_req_t                LINK_RX_REQ,
   output logic                                  LINK_RX_READY,
   // Completions to the link
   output logic                                  LINK_CPL_VALID,
   output pmb_pkg::pmb_cpl_t                     LINK_CPL,
   input  wire logic                             LINK_CPL_READY,
   // Receive BAR master to the fabric
   output logic [pmb_pkg::ADDR_W-1:0]            RXM_ADDR,
   output logic                                  RXM_WRITE,
   output logic                                  RXM_READ,
   output logic [pmb_pkg::MAX_W-1:0]             RXM_WDATA,
   input  wire logic                             RXM_WAIT,
   input  wire logic [pmb_pkg::MAX_W-1:0]        RXM_RDATA,
   input  wire logic                             RXM_RDVALID,
   // Transmit slave from the fabric
   input  wire logic                             TXS_VALID,
   input  wire pmb_pkg::pmb_req_t                TXS_REQ,
   output logic                                  TXS_READY,
   // Requests to the link
   output logic                                  LINK_TX_VALID,
   output pmb_pkg::pmb_req_t                     LINK_TX_REQ,
   input  wire logic                             LINK_TX_READY,
   // Exported message interrupt interfaces
   input  wire logic                             MSI_REQ,
   input  wire logic [pmb_pkg::MSI_NUM_W-1:0]    MSI_NUM,
   output logic                                  MSI_ACK,
   input  wire logic                             MSIX_REQ,
   input  wire logic [pmb_pkg::MSIX_IDX_W-1:0]   MSIX_IDX,
   output logic                                  MSIX_ACK,
   // Message interrupts to the link
   output logic                                  LINK_MSI_VALID,
   output logic [pmb_pkg::MSI_NUM_W-1:0]         LINK_MSI_NUM,
   output logic                                  LINK_MSIX_VALID,
   output logic [pmb_pkg::MSIX_IDX_W-1:0]        LINK_MSIX_IDX,
   input  wire logic                             LINK_MSI_ACK,
   // Interrupt line
   output logic                                  IRQ
);

   // ============================================================
   // Build-time derived options
   localparam bit ONE_WORD  = (ROLE == pmb_pkg::ROLE_ONE_WORD);
   localparam bit HAS_TXS   = (ROLE == pmb_pkg::ROLE_REQ_CPL);
   localparam bit HAS_CTRL  = (ROLE == pmb_pkg::ROLE_REQ_CPL) ||
                              ((ROLE == pmb_pkg::ROLE_CPL_ONLY) && CTRL_PORT_OPT);
   localparam int DATA_W    = ONE_WORD  ? pmb_pkg::WORD_W :
                              WIDE_DATA ? pmb_pkg::WIDE_W : pmb_pkg::NARROW_W;
   localparam logic [pmb_pkg::MAX_W-1:0] DMASK = {pmb_pkg::MAX_W{1'b1}} >> (pmb_pkg::MAX_W - DATA_W);
   localparam logic [1:0] DEPTH = ONE_WORD ? pmb_pkg::ONE_DEPTH : pmb_pkg::PIPE_DEPTH;

   // ============================================================
   // Receive path state machine
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_ISSUE = 4'b0010,
      ST_WAIT  = 4'b0100,
      ST_CPL   = 4'b1000
   } pmb_rx_state_t;

   pmb_rx_state_t     state;
   pmb_rx_state_t     next_state;
   pmb_pkg::pmb_req_t cur;
   pmb_pkg::pmb_req_t next_cur;
   pmb_pkg::pmb_cpl_t cpl;
   pmb_pkg::pmb_cpl_t next_cpl;
   logic [1:0]        outst;
   logic [1:0]        next_outst;
   logic              rx_take;
   logic              cpl_done;

   // Pipelined roles may take the next request while a completion drains
   assign LINK_RX_READY = (state == ST_IDLE) ||
                          ((state == ST_CPL) && LINK_CPL_READY && (outst < DEPTH));
   assign rx_take  = LINK_RX_VALID && LINK_RX_READY;
   assign cpl_done = (state == ST_CPL) && LINK_CPL_READY;

   always_comb begin
      next_state = state;
      next_cur   = cur;
      next_cpl   = cpl;
      next_outst = outst;
      case (state)
         ST_IDLE: begin
            if (rx_take) begin
               next_state     = ST_ISSUE;
               next_cur       = LINK_RX_REQ;
               next_cur.data  = LINK_RX_REQ.data & DMASK;
               next_outst     = 2'h1;
            end
         end
         ST_ISSUE: begin
            if (!RXM_WAIT) begin
               if (cur.write) begin
                  next_state = ST_IDLE;                     // Writes are posted: no completion
                  next_outst = 2'h0;
               end else begin
                  next_state = ST_WAIT;
               end
            end
         end
         ST_WAIT: begin
            if (RXM_RDVALID) begin
               next_state    = ST_CPL;
               next_cpl.tag  = cur.tag;
               next_cpl.data = RXM_RDATA & DMASK;
            end
         end
         ST_CPL: begin
            if (cpl_done) begin
               if (rx_take) begin
                  next_state    = ST_ISSUE;
                  next_cur      = LINK_RX_REQ;
                  next_cur.data = LINK_RX_REQ.data & DMASK;
                  next_outst    = 2'h1;
               end else begin
                  next_state = ST_IDLE;
                  next_outst = 2'h0;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_outst = 2'h0;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         state <= ST_IDLE;
         cur   <= '0;
         cpl   <= '0;
         outst <= 2'h0;
      end else begin
         state <= next_state;
         cur   <= next_cur;
         cpl   <= next_cpl;
         outst <= next_outst;
      end
   end

   // Command and data held in flip-flops through the whole issue phase
   assign RXM_ADDR       = cur.addr;
   assign RXM_WDATA      = cur.data;
   assign RXM_WRITE      = (state == ST_ISSUE) && cur.write;
   assign RXM_READ       = (state == ST_ISSUE) && !cur.write;
   assign LINK_CPL_VALID = (state == ST_CPL);
   assign LINK_CPL       = cpl;

   // ============================================================
   // Transmit path: fabric slave to link requests
   logic              tx_valid;
   logic              next_tx_valid;
   pmb_pkg::pmb_req_t tx_req;
   pmb_pkg::pmb_req_t next_tx_req;
   logic              tx_sent;

   // Single holding stage; a free stage or a draining one accepts
   assign TXS_READY = HAS_TXS && (!tx_valid || LINK_TX_READY);
   assign tx_sent   = tx_valid && LINK_TX_READY;

   always_comb begin
      next_tx_valid = tx_valid;
      next_tx_req   = tx_req;
      if (tx_sent) begin
         next_tx_valid = 1'b0;
      end
      if (TXS_VALID && TXS_READY) begin
         next_tx_valid      = 1'b1;
         next_tx_req        = TXS_REQ;
         next_tx_req.data   = TXS_REQ.data & DMASK;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         tx_valid <= 1'b0;
         tx_req   <= '0;
      end else begin
         tx_valid <= next_tx_valid;
         tx_req   <= next_tx_req;
      end
   end

   assign LINK_TX_VALID = tx_valid;     // Never set without the slave port
   assign LINK_TX_REQ   = tx_req;

   // ============================================================
   // Event status and interrupt enable
   logic [pmb_pkg::EV_W-1:0] isr;
   logic [pmb_pkg::EV_W-1:0] next_isr;
   logic [pmb_pkg::EV_W-1:0] ier;
   logic [pmb_pkg::EV_W-1:0] next_ier;
   logic [pmb_pkg::EV_W-1:0] ev;
   logic                     acc;
   logic                     hit_isr;
   logic                     hit_ier;
   logic                     hit_cfg;
   logic                     mapped;

   assign ev[pmb_pkg::EV_RX_TAKEN] = rx_take;
   assign ev[pmb_pkg::EV_CPL_SENT] = cpl_done;
   assign ev[pmb_pkg::EV_TX_SENT]  = tx_sent;

   // Zero-wait slave: every access phase completes in its first cycle
   assign acc     = PSEL && PENABLE && HAS_CTRL;
   assign hit_isr = (PADDR == pmb_pkg::OFS_ISR);
   assign hit_ier = (PADDR == pmb_pkg::OFS_IER);
   assign hit_cfg = (PADDR == pmb_pkg::OFS_CFG);
   assign mapped  = hit_isr || hit_ier || hit_cfg;

   always_comb begin
      next_isr = isr;
      next_ier = ier;
      if (acc && !PWRITE && hit_isr) begin
         next_isr = '0;                                   // Read clears
      end
      next_isr = next_isr | ev;                           // Event beats the clear
      if (acc && PWRITE && hit_ier) begin
         next_ier = PWDATA[pmb_pkg::EV_W-1:0];
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         isr <= '0;
         ier <= AUTO_IRQ_EN ? pmb_pkg::IER_ON : pmb_pkg::IER_OFF;
      end else begin
         isr <= next_isr;
         ier <= next_ier;
      end
   end

   assign IRQ = |(isr & ier);

   // ============================================================
   // APB read data and answer
   logic [31:0] cfg_word;
   logic [31:0] next_prdata;

   always_comb begin
      cfg_word = '0;
      cfg_word[pmb_pkg::CFG_ROLE_LSB +: 2] = ROLE;
      cfg_word[pmb_pkg::CFG_WIDE_BIT]      = WIDE_DATA && !ONE_WORD;
      cfg_word[pmb_pkg::CFG_MSI_BIT]       = MULTI_MSI;
      cfg_word[pmb_pkg::CFG_AUTO_BIT]      = AUTO_IRQ_EN;
   end

   always_comb begin
      next_prdata = '0;
      if (HAS_CTRL && PSEL && !PENABLE && !PWRITE) begin
         if (hit_isr) begin
            next_prdata = {{(32-pmb_pkg::EV_W){1'b0}}, isr | ev};
         end else if (hit_ier) begin
            next_prdata = {{(32-pmb_pkg::EV_W){1'b0}}, ier};
         end else if (hit_cfg) begin
            next_prdata = cfg_word;
         end
      end else if (PSEL && PENABLE) begin
         next_prdata = PRDATA;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         PRDATA <= '0;
      end else begin
         PRDATA <= next_prdata;
      end
   end

   assign PREADY  = 1'b1;
   // Without the control port every access errors
   assign PSLVERR = PSEL && PENABLE && (!HAS_CTRL || !mapped);

   // ============================================================
   // Message interrupts: exported or driven from the interrupt line
   logic                           msi_v;
   logic                           next_msi_v;
   logic [pmb_pkg::MSI_NUM_W-1:0]  msi_n;
   logic [pmb_pkg::MSI_NUM_W-1:0]  next_msi_n;
   logic                           msix_v;
   logic                           next_msix_v;
   logic [pmb_pkg::MSIX_IDX_W-1:0] msix_i;
   logic [pmb_pkg::MSIX_IDX_W-1:0] next_msix_i;
   logic                           irq_d;
   logic                           msi_src;

   // Internal source signals one message per rising interrupt
   assign msi_src = MULTI_MSI ? MSI_REQ : (IRQ && !irq_d);

   always_comb begin
      next_msi_v  = msi_v;
      next_msi_n  = msi_n;
      next_msix_v = msix_v;
      next_msix_i = msix_i;
      if (msi_v && LINK_MSI_ACK) begin
         next_msi_v = 1'b0;
      end else if (msix_v && LINK_MSI_ACK) begin
         next_msix_v = 1'b0;
      end
      if (!msi_v && msi_src) begin
         next_msi_v = 1'b1;
         next_msi_n = MULTI_MSI ? MSI_NUM : '0;
      end
      if (MULTI_MSI && !msix_v && MSIX_REQ) begin
         next_msix_v = 1'b1;
         next_msix_i = MSIX_IDX;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         msi_v  <= 1'b0;
         msi_n  <= '0;
         msix_v <= 1'b0;
         msix_i <= '0;
         irq_d  <= 1'b0;
      end else begin
         msi_v  <= next_msi_v;
         msi_n  <= next_msi_n;
         msix_v <= next_msix_v;
         msix_i <= next_msix_i;
         irq_d  <= IRQ;
      end
   end

   assign LINK_MSI_VALID  = msi_v;
   assign LINK_MSI_NUM    = msi_n;
   assign LINK_MSIX_VALID = msix_v && !msi_v;
   assign LINK_MSIX_IDX   = msix_i;
   assign MSI_ACK  = MULTI_MSI && msi_v && LINK_MSI_ACK;
   assign MSIX_ACK = MULTI_MSI && msix_v && !msi_v && LINK_MSI_ACK;

endmodule

`default_nettype wire

// ==== sim/pmb_bridge_mode_assertions.sv ====
// Port checker for the bridge mode block, with its bind
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Checker
module pmb_chk #(
   parameter pmb_pkg::pmb_role_t ROLE      = pmb_pkg::ROLE_REQ_CPL,
   parameter bit                 WIDE_DATA = 1'b0
) (
   // Clock, reset and register slave
   input wire logic              CLK,
   input wire logic              RST,
   input wire logic              PSEL,
   input wire logic              PENABLE,
   input wire logic [11:0]       PADDR,
   input wire logic              PREADY,
   input wire logic              PSLVERR,
   // Link and fabric
   input wire logic              LINK_RX_VALID,
   input wire logic              LINK_RX_READY,
   input wire logic              LINK_CPL_VALID,
   input wire pmb_pkg::pmb_cpl_t LINK_CPL,
   input wire logic              LINK_CPL_READY,
   input wire logic              RXM_READ,
   input wire logic              RXM_WRITE,
   input wire logic [31:0]       RXM_ADDR,
   input wire logic [127:0]      RXM_WDATA,
   input wire logic              RXM_WAIT,
   input wire logic              RXM_RDVALID,
   input wire logic              TXS_VALID,
   input wire pmb_pkg::pmb_req_t TXS_REQ,
   input wire logic              TXS_READY,
   input wire logic              LINK_TX_VALID,
   input wire pmb_pkg::pmb_req_t LINK_TX_REQ
);
   default clocking @(posedge CLK);
   endclocking
   default disable iff (RST);

   a_ready_now: assert property (PREADY)
      else $error("register slave stalled");
   a_unmapped_err: assert property (PSEL && PENABLE && PADDR > pmb_pkg::OFS_CFG
      |-> PSLVERR) else $error("unmapped access not refused");
   a_rx_single: assert property (LINK_RX_VALID && LINK_RX_READY
      |=> !LINK_RX_READY && (RXM_READ || RXM_WRITE)) else $error("rx overlap");
   a_rxm_hold: assert property ((RXM_READ || RXM_WRITE) && RXM_WAIT
      |=> $stable(RXM_ADDR) && $stable(RXM_READ) && $stable(RXM_WRITE)) else $error("rxm moved");
   a_cpl_hold: assert property (LINK_CPL_VALID && !LINK_CPL_READY
      |=> LINK_CPL_VALID && $stable(LINK_CPL)) else $error("completion dropped");
   a_cpl_follow: assert property (RXM_RDVALID |=> LINK_CPL_VALID)
      else $error("no completion after read data");
   a_width_mask: assert property (WIDE_DATA || (RXM_WDATA[127:64] == 64'h0
      && LINK_CPL.data[127:64] == 64'h0)) else $error("upper data bits set");
   a_tx_take: assert property (TXS_VALID && TXS_READY
      |=> LINK_TX_VALID && LINK_TX_REQ.addr == $past(TXS_REQ.addr)) else $error("tx lost");
   a_txs_role: assert property (TXS_READY |-> ROLE == pmb_pkg::ROLE_REQ_CPL)
      else $error("tx slave present in completer role");
endmodule

bind pmb_bridge_mode pmb_chk #(.ROLE(ROLE), .WIDE_DATA(WIDE_DATA)) i_chk (
   .CLK, .RST, .PSEL, .PENABLE, .PADDR, .PREADY, .PSLVERR, .LINK_RX_VALID, .LINK_RX_READY,
   .LINK_CPL_VALID, .LINK_CPL, .LINK_CPL_READY, .RXM_READ, .RXM_WRITE, .RXM_ADDR, .RXM_WDATA,
   .RXM_WAIT, .RXM_RDVALID, .TXS_VALID, .TXS_REQ, .TXS_READY, .LINK_TX_VALID, .LINK_TX_REQ);
`default_nettype wire

// ==== sim/pmb_fabric_model.sv ====
// Fabric slave model standing behind the receive master
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Memory slave
module pmb_fabric_model (
   // Clock and reset
   input  wire logic         CLK,
   input  wire logic         RST,
   // Master side and test control
   input  wire logic         RXM_READ,
   input  wire logic         RXM_WRITE,
   input  wire logic [31:0]  RXM_ADDR,
   input  wire logic [127:0] RXM_WDATA,
   output logic              RXM_WAIT,
   output logic [127:0]      RXM_RDATA,
   output logic              RXM_RDVALID,
   input  wire logic         SLOW
);
   logic [127:0] mem [16];
   logic         waited;
   logic         pend;
   logic [3:0]   idx;
   wire logic    cmd = RXM_READ || RXM_WRITE;

   // Slow mode stalls every command once
   assign RXM_WAIT = SLOW && cmd && !waited;
   always_ff @(posedge CLK) begin
      if (RST) begin
         waited      <= 1'b0;
         pend        <= 1'b0;
         RXM_RDVALID <= 1'b0;
      end else begin
         waited      <= cmd && RXM_WAIT;
         pend        <= cmd && !RXM_WAIT && RXM_READ;
         RXM_RDVALID <= pend;
         if (cmd && !RXM_WAIT) begin
            idx <= RXM_ADDR[5:2];
            if (RXM_WRITE) mem[RXM_ADDR[5:2]] <= RXM_WDATA;
         end
      end
   end
   // Junk upper half a narrow bridge must drop; scrambled when idle
   always_ff @(posedge CLK) begin
      RXM_RDATA <= pend ? {~mem[idx][63:0], mem[idx][63:0]} : ~RXM_RDATA;
   end
endmodule
`default_nettype wire

// ==== sim/tb_pmb_bridge_mode.sv ====
// Self-checking bench for the bridge mode block
`timescale 1ns/100ps
`default_nettype none
module tb_pmb_bridge_mode;
   typedef struct packed {
      logic        wr;
      logic [31:0] addr;
      logic [7:0]  tag;
   } pmb_row_t;
   localparam logic [127:0] MASK = {64'h0, {64{1'b1}}};
   localparam pmb_row_t ROWS [4] = '{'{1'b1, 32'h10, 8'h01}, '{1'b1, 32'h24, 8'h02},
                                     '{1'b0, 32'h10, 8'h83}, '{1'b0, 32'h24, 8'hff}};
   logic clk = 1'b0, rst = 1'b1, slow = 1'b0, err;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd, rxm_addr;
   logic rx_valid = 1'b0, rx_ready, cpl_valid, cpl_ready = 1'b0;
   logic txs_valid = 1'b0, txs_ready, tx_valid, tx_ready = 1'b0;
   logic msi_req = 1'b0, msix_req = 1'b0, msi_ack, msix_ack, msg_ack = 1'b0;
   logic msi_valid, msix_valid, rxm_read, rxm_write, rxm_wait, rxm_rdvalid;
   logic [4:0] msi_num, msi_num_in = 5'h0;
   logic [10:0] msix_idx, msix_idx_in = 11'h0;
   logic [127:0] rxm_wdata, rxm_rdata, dat, shadow [16];
   pmb_pkg::pmb_req_t rx_req = '0, txs_req = '0, tx_req;
   pmb_pkg::pmb_cpl_t link_cpl;
   int bad_count = 0, cmp_count = 0;

   pmb_bridge_mode #(.ROLE(pmb_pkg::ROLE_REQ_CPL), .WIDE_DATA(1'b0), .CTRL_PORT_OPT(1'b1),
                     .MULTI_MSI(1'b1), .AUTO_IRQ_EN(1'b1)) i_dut (
      .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .LINK_RX_VALID(rx_valid), .LINK_RX_REQ(rx_req), .LINK_RX_READY(rx_ready),
      .LINK_CPL_VALID(cpl_valid), .LINK_CPL(link_cpl), .LINK_CPL_READY(cpl_ready),
      .RXM_ADDR(rxm_addr), .RXM_WRITE(rxm_write), .RXM_READ(rxm_read), .RXM_WDATA(rxm_wdata),
      .RXM_WAIT(rxm_wait), .RXM_RDATA(rxm_rdata), .RXM_RDVALID(rxm_rdvalid),
      .TXS_VALID(txs_valid), .TXS_REQ(txs_req), .TXS_READY(txs_ready),
      .LINK_TX_VALID(tx_valid), .LINK_TX_REQ(tx_req), .LINK_TX_READY(tx_ready),
      .MSI_REQ(msi_req), .MSI_NUM(msi_num_in), .MSI_ACK(msi_ack),
      .MSIX_REQ(msix_req), .MSIX_IDX(msix_idx_in), .MSIX_ACK(msix_ack),
      .LINK_MSI_VALID(msi_valid), .LINK_MSI_NUM(msi_num), .LINK_MSIX_VALID(msix_valid),
      .LINK_MSIX_IDX(msix_idx), .LINK_MSI_ACK(msg_ack), .IRQ(irq));
   pmb_fabric_model i_fab (.CLK(clk), .RST(rst), .RXM_READ(rxm_read), .RXM_WRITE(rxm_write),
      .RXM_ADDR(rxm_addr), .RXM_WDATA(rxm_wdata), .RXM_WAIT(rxm_wait), .RXM_RDATA(rxm_rdata),
      .RXM_RDVALID(rxm_rdvalid), .SLOW(slow));

   always #25 clk = ~clk;

   // ============================================================
   // Drivers and checks
   task automatic chk(string what, logic [127:0] e, logic [127:0] got);
      cmp_count++;
      if (got !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, e, got);
      end
   endtask
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // Answer and read data taken at the edge that ends the access phase
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic reg_chk(logic [11:0] a, logic [31:0] e, logic ee);
      apb(1'b0, a, 32'h0);
      chk("prdata", e, rd);
      chk("pslverr", ee, err);
   endtask
   task automatic irq_is(logic e);
      @(negedge clk);
      chk("irq", e, irq);
   endtask
   // Request fields are scrambled once taken
   task automatic rx(logic wr, logic [31:0] a, logic [7:0] t, logic [127:0] d);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_req <= '{wr, a, t, d};
      @(negedge clk);
      while (rx_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_req <= ~rx_req;
   endtask
   // Completion is stalled one cycle before acceptance
   task automatic cpl(logic [7:0] t, logic [127:0] d);
      @(negedge clk);
      while (cpl_valid !== 1'b1) @(negedge clk);
      chk("cpl tag", t, link_cpl.tag);
      chk("cpl data", d, link_cpl.data);
      @(posedge clk);
      cpl_ready <= 1'b1;
      @(posedge clk);
      cpl_ready <= 1'b0;
   endtask
   // Request held until the link acknowledge is passed back
   task automatic msg(logic x, logic [10:0] v);
      @(posedge clk);
      msi_req <= !x;
      msix_req <= x;
      msi_num_in <= v[4:0];
      msix_idx_in <= v;
      @(negedge clk);
      while ((x ? msix_valid : msi_valid) !== 1'b1) @(negedge clk);
      if (x) chk("msix idx", v, msix_idx);
      else chk("msi num", v[4:0], msi_num);
      @(posedge clk);
      msg_ack <= 1'b1;
      @(negedge clk);
      chk("msg ack", 1'b1, x ? msix_ack : msi_ack);
      @(posedge clk);
      msg_ack <= 1'b0;
      msi_req <= 1'b0;
      msix_req <= 1'b0;
   endtask
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ============================================================
   // Sequence
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      end_sim();
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      foreach (ROWS[i]) begin
         slow <= i[0];
         dat = {4{32'hc0de0000 + 32'(i)}};
         if (ROWS[i].wr) shadow[ROWS[i].addr[5:2]] = dat & MASK;
         rx(ROWS[i].wr, ROWS[i].addr, ROWS[i].tag, dat);
         if (!ROWS[i].wr) cpl(ROWS[i].tag, shadow[ROWS[i].addr[5:2]]);
      end
      irq_is(1'b1);
      reg_chk(pmb_pkg::OFS_ISR, 32'h3, 1'b0);
      irq_is(1'b0);
      apb(1'b1, pmb_pkg::OFS_IER, 32'h0);
      reg_chk(pmb_pkg::OFS_IER, 32'h0, 1'b0);
      rx(1'b1, 32'h30, 8'h05, '1);
      irq_is(1'b0);
      apb(1'b1, pmb_pkg::OFS_IER, 32'h1);
      irq_is(1'b1);
      reg_chk(pmb_pkg::OFS_ISR, 32'h1, 1'b0);
      reg_chk(12'h00c, 32'h0, 1'b1);
      @(posedge clk);
      txs_valid <= 1'b1;
      txs_req <= '{1'b1, 32'h40, 8'h07, {2{64'h0123456789abcdef}}};
      @(negedge clk);
      while (txs_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
      txs_valid <= 1'b0;
      txs_req <= ~txs_req;
      @(negedge clk);
      while (tx_valid !== 1'b1) @(negedge clk);
      chk("tx addr", 32'h40, tx_req.addr);
      chk("tx data", {64'h0, 64'h0123456789abcdef}, tx_req.data);
      @(posedge clk);
      tx_ready <= 1'b1;
      @(posedge clk);
      tx_ready <= 1'b0;
      reg_chk(pmb_pkg::OFS_ISR, 32'h4, 1'b0);
      msg(1'b0, 11'h013);
      msg(1'b1, 11'h5a5);
      @(posedge clk);
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      reg_chk(pmb_pkg::OFS_IER, 32'h7, 1'b0);
      reg_chk(pmb_pkg::OFS_CFG, 32'h60, 1'b0);
      end_sim();
   end
endmodule
`default_nettype wire
